// [hdl/cmsr_defines.svh]
/*
  Offsets, field positions, reset values and timing counts for the charger
  measurement and status register bank.
  Assumes a 50 MHz system clock and 8-bit register addresses.
*/
`ifndef CMSR_DEFINES_SVH
`define CMSR_DEFINES_SVH

`define CMSR_DEV_ADDR 7'h2a
`define CMSR_CHANNELS 7

`define CMSR_OFF_CTRL 8'h06
`define CMSR_OFF_CONV 8'h07
`define CMSR_OFF_VIN_HI 8'h13
`define CMSR_OFF_VIN_LO 8'h14
`define CMSR_OFF_IIN_HI 8'h15
`define CMSR_OFF_IIN_LO 8'h16
`define CMSR_OFF_VOUT_HI 8'h17
`define CMSR_OFF_VOUT_LO 8'h18
`define CMSR_OFF_VDROP_HI 8'h19
`define CMSR_OFF_VDROP_LO 8'h1a
`define CMSR_OFF_VBAT_HI 8'h1b
`define CMSR_OFF_VBAT_LO 8'h1c
`define CMSR_OFF_TIN_HI 8'h1f
`define CMSR_OFF_TIN_LO 8'h20
`define CMSR_OFF_TBAT_HI 8'h21
`define CMSR_OFF_TBAT_LO 8'h22
`define CMSR_OFF_TDIE 8'h23
`define CMSR_OFF_STA 8'h24
`define CMSR_OFF_STB 8'h25
`define CMSR_OFF_RLIM 8'h26
`define CMSR_OFF_RTIM 8'h27
`define CMSR_OFF_OVTIM 8'h28

`define CMSR_RST_CTRL 8'h2a
`define CMSR_RST_CONV 8'h8f
`define CMSR_RST_RLIM 8'h01
`define CMSR_RST_RTIM 8'h03
`define CMSR_RST_OVTIM 8'h0c
`define CMSR_RST_RES 8'h00
`define CMSR_RST_TS_HI 8'h03
`define CMSR_RST_TS_LO 8'h84

`define CMSR_CHG_BIT 4
`define CMSR_MODE_BIT 2
`define CMSR_SEL_HI 3
`define CMSR_SEL_LO 2
`define CMSR_DIS_EN_BIT 1
`define CMSR_DIS_W_BIT 0
`define CMSR_RLIM_MAX 4'h8

`define CMSR_CLK_MHZ 50
`define CMSR_TICK_NS 111
`define CMSR_TICK_CYC ((`CMSR_TICK_NS * `CMSR_CLK_MHZ + 999) / 1000)
`define CMSR_FILT_MAX 6'h20
`define CMSR_REV_LONG_US 16
`define CMSR_REV_SHORT_US 8
`define CMSR_OV_LONG_US 8
`define CMSR_OV_SHORT_US 4
`define CMSR_US_CYC(us) ((us) * `CMSR_CLK_MHZ)

`endif

// [hdl/cmsr_pkg.sv]
/*
  Types shared by the register bank and its fault filters.
  Assumes nothing beyond the defines header.
*/
`default_nettype none
package cmsr_pkg;
  typedef enum logic [2:0] {
    cmsr_idle = 3'b000,
    cmsr_addr = 3'b001,
    cmsr_addr_ack = 3'b011,
    cmsr_wr = 3'b010,
    cmsr_wr_ack = 3'b110,
    cmsr_rd = 3'b111,
    cmsr_rd_ack = 3'b101
  } cmsr_port_state_t;
  typedef logic [12:0] cmsr_mag_t;
  typedef logic [7:0] cmsr_byte_t;
endpackage
`default_nettype wire

// [hdl/cmsr_fault_if.sv]
/*
  Carrier between the register bank and one fault filter.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface cmsr_fault_if;
  logic tick;
  logic raw;
  logic [1:0] sel;
  logic dis_en;
  logic dis_short;
  logic fault;
  logic pulse;
  modport filt (input tick, raw, sel, dis_en, dis_short,
                output fault, pulse);
  modport ctl (output tick, raw, sel, dis_en, dis_short,
               input fault, pulse);
endinterface
`default_nettype wire

// [hdl/cmsr_fault_filter.sv]
/*
  Deglitch filter and fast-discharge pulse generator for one fault.
  Assumes a one-cycle tick every 120 ns (111 ns rounded up to six cycles) from the bank's divider.
*/
`include "cmsr_defines.svh"
`default_nettype none
module cmsr_fault_filter
  import cmsr_pkg::*;
#(
  parameter logic [9:0] LONG_CYC = 10'd800,
  parameter logic [9:0] SHORT_CYC = 10'd400
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link to the bank
  cmsr_fault_if.filt f
);
  logic [5:0] count;
  logic [5:0] next_count;
  logic [5:0] target;
  logic fault_q;
  logic next_fault;
  logic [9:0] pcnt;
  logic [9:0] next_pcnt;
  logic pulse_q;
  logic next_pulse;

  always_comb begin
    target = `CMSR_FILT_MAX >> f.sel;
    next_count = count;
    // Restart as soon as the raw condition drops
    if (!f.raw) begin
      next_count = 6'h00; // R23
    end else if (f.tick && count != target) begin
      next_count = count + 6'h01; // R23
    end
    next_fault = f.raw && (next_count == target); // R23
    next_pcnt = pcnt;
    if (next_fault && !fault_q && f.dis_en) begin
      next_pcnt = f.dis_short ? SHORT_CYC : LONG_CYC; // R18 R20
    end else if (pcnt != 10'h000) begin
      next_pcnt = pcnt - 10'h001;
    end
    next_pulse = next_pcnt != 10'h000;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 6'h00;
      fault_q <= 1'b0;
      pcnt <= 10'h000;
      pulse_q <= 1'b0;
    end else begin
      count <= next_count;
      fault_q <= next_fault;
      pcnt <= next_pcnt;
      pulse_q <= next_pulse;
    end
  end

  assign f.fault = fault_q;
  assign f.pulse = pulse_q;
endmodule
`default_nettype wire

// [hdl/cmsr_regs.sv]
/*
  Measurement, status and protection-control register bank reached over
  the two-wire serial port, with deglitch and fast-discharge control.
  Assumes all inputs are synchronous to mclk and that the converter holds
  its result inputs stable from one valid strobe to the next.
*/
`include "cmsr_defines.svh"
`default_nettype none
// Summary of operation
// R01: Input voltage: 13-bit mV, split, sign bit7
// R02: Input current: 1 mA, same split, sign
// R03: Dropout high byte: two magnitude bits, sign
// R04: Temperature sense: 4-bit high, resets 03/84
// R05: Die temperature: unsigned byte, reset zero
// R06: Status A bit7: input over-voltage
// R07: Status A bits 6,5,3: linear regulation
// R08: Status A bits 2,1: sense over-temperature
// R09: Status A bit0 reverse current, switch off
// R10: Status B bit7: low charge alarm
// R11: Status B bit6: single-shot conversion done
// R12: Status B bits 5,4: dropout alarms
// R13: Status B bits 3,2: input/battery present
// R14: Status B bit1: thermal shutdown
// R15: Status B bit0: forward over-current
// R16: Reverse threshold 4 bits, max 8, reset 1
// R17: Reverse deglitch select, 32..4 ticks, default 00
// R18: Reverse discharge pulse 16/8 us, enabled
// R19: Over-voltage deglitch same encoding, default 11
// R20: Over-voltage discharge pulse 8/4 us, disabled
// R21: Mode bit: single-shot or continuous conversion
// R22: Charge enable cleared by reset, faults
// R23: Deglitch counts ticks, restarts on drop
// R24: Result pairs update together, never torn
module cmsr_regs
  import cmsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CMSR_DEV_ADDR
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Two-wire serial port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Converter results
  input wire logic meas_valid,
  input wire logic [6:0] meas_sign,
  input wire logic [6:0][12:0] meas_mag,
  input wire logic [7:0] die_temp,
  output logic convert_continuous,
  // Comparator levels
  input wire logic input_overvoltage_raw,
  input wire logic reverse_current_raw,
  input wire logic input_current_regulating_flag,
  input wire logic battery_voltage_regulating_flag,
  input wire logic output_voltage_regulating_flag,
  input wire logic input_side_overtemp_flag,
  input wire logic battery_side_overtemp_flag,
  input wire logic low_current_raw,
  input wire logic dropout_alarm_flag,
  input wire logic dropout_overvoltage_flag,
  input wire logic input_present_flag,
  input wire logic battery_present_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic forward_overcurrent_flag,
  input wire logic switch_off_event,
  // Switch control
  output logic charge_switch_enable,
  output logic [3:0] reverse_overcurrent_threshold,
  output logic [1:0] fast_discharge_output
);
  localparam int CH = `CMSR_CHANNELS;
  localparam logic [7:0] HI_OFF [CH] = '{`CMSR_OFF_VIN_HI,
    `CMSR_OFF_IIN_HI, `CMSR_OFF_VOUT_HI, `CMSR_OFF_VDROP_HI,
    `CMSR_OFF_VBAT_HI, `CMSR_OFF_TIN_HI, `CMSR_OFF_TBAT_HI};
  localparam logic [7:0] LO_OFF [CH] = '{`CMSR_OFF_VIN_LO,
    `CMSR_OFF_IIN_LO, `CMSR_OFF_VOUT_LO, `CMSR_OFF_VDROP_LO,
    `CMSR_OFF_VBAT_LO, `CMSR_OFF_TIN_LO, `CMSR_OFF_TBAT_LO};
  localparam logic [4:0] HI_MASK [CH] = '{5'h1f, 5'h1f, 5'h1f, 5'h03,
    5'h1f, 5'h0f, 5'h0f};
  localparam logic [7:0] HI_RST [CH] = '{`CMSR_RST_RES, `CMSR_RST_RES,
    `CMSR_RST_RES, `CMSR_RST_RES, `CMSR_RST_RES, `CMSR_RST_TS_HI,
    `CMSR_RST_TS_HI};
  localparam logic [7:0] LO_RST [CH] = '{`CMSR_RST_RES, `CMSR_RST_RES,
    `CMSR_RST_RES, `CMSR_RST_RES, `CMSR_RST_RES, `CMSR_RST_TS_LO,
    `CMSR_RST_TS_LO};
  localparam logic [2:0] TICK_LAST = 3'(`CMSR_TICK_CYC - 1);

  // Serial port state
  cmsr_port_state_t state;
  cmsr_port_state_t next_state;
  cmsr_byte_t sh;
  cmsr_byte_t next_sh;
  cmsr_byte_t ptr;
  cmsr_byte_t next_ptr;
  cmsr_byte_t rd_byte;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic ptr_phase;
  logic next_ptr_phase;
  logic rw;
  logic next_rw;
  logic next_oe;
  logic busy;
  logic next_busy;
  logic scl_q;
  logic sda_q;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic wr_en;
  logic rd_load;

  // Control registers
  cmsr_byte_t ctrl;
  cmsr_byte_t next_ctrl;
  cmsr_byte_t conv;
  cmsr_byte_t next_conv;
  logic [3:0] rlim;
  logic [3:0] next_rlim;
  cmsr_byte_t rtim;
  cmsr_byte_t next_rtim;
  cmsr_byte_t ovtim;
  cmsr_byte_t next_ovtim;
  logic fault_off;

  // Results and status
  cmsr_byte_t res_hi [CH];
  cmsr_byte_t next_res_hi [CH];
  cmsr_byte_t res_lo [CH];
  cmsr_byte_t next_res_lo [CH];
  cmsr_byte_t cap_hi [CH];
  cmsr_byte_t cap_lo [CH];
  cmsr_byte_t tdie;
  cmsr_byte_t next_tdie;
  logic pending;
  logic next_pending;
  logic update;
  cmsr_byte_t sta;
  cmsr_byte_t next_sta;
  cmsr_byte_t stb;
  cmsr_byte_t next_stb;
  logic adc_done;
  logic next_adc_done;

  // Tick divider and filters
  logic [2:0] div;
  logic [2:0] next_div;
  logic tick;
  logic [1:0] flt_raw;
  logic [1:0] flt_fault;
  logic [1:0][7:0] flt_tim;

  // Capture values per channel, narrowed to each channel's field
  for (genvar k = 0; k < CH; k++) begin : g_ch
    assign cap_hi[k] = {meas_sign[k], 2'b00,
                        meas_mag[k][12:8] & HI_MASK[k]}; // R01 R02 R03 R04
    assign cap_lo[k] = meas_mag[k][7:0];
  end

  // Bit 1 handles reverse current, bit 0 input over-voltage
  assign flt_raw = {reverse_current_raw, input_overvoltage_raw};
  assign flt_tim = {rtim, ovtim};
  for (genvar k = 0; k < 2; k++) begin : g_flt
    cmsr_fault_if fif ();
    assign fif.tick = tick;
    assign fif.raw = flt_raw[k];
    assign fif.sel = flt_tim[k][`CMSR_SEL_HI:`CMSR_SEL_LO]; // R17 R19
    assign fif.dis_en = flt_tim[k][`CMSR_DIS_EN_BIT];
    assign fif.dis_short = flt_tim[k][`CMSR_DIS_W_BIT];
    assign flt_fault[k] = fif.fault;
    assign fast_discharge_output[k] = fif.pulse;
    cmsr_fault_filter #(
      .LONG_CYC(10'(`CMSR_US_CYC(k == 1 ? `CMSR_REV_LONG_US
                                        : `CMSR_OV_LONG_US))),
      .SHORT_CYC(10'(`CMSR_US_CYC(k == 1 ? `CMSR_REV_SHORT_US
                                         : `CMSR_OV_SHORT_US)))
    ) u_filter (
      .mclk(mclk),
      .rst_n(rst_n),
      .f(fif.filt)
    );
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < CH; k++) begin
      if (ptr == HI_OFF[k]) begin
        rd_byte = res_hi[k];
      end
      if (ptr == LO_OFF[k]) begin
        rd_byte = res_lo[k];
      end
    end
    case (ptr)
      `CMSR_OFF_CTRL: rd_byte = ctrl;
      `CMSR_OFF_CONV: rd_byte = conv;
      `CMSR_OFF_TDIE: rd_byte = tdie;
      `CMSR_OFF_STA: rd_byte = sta;
      `CMSR_OFF_STB: rd_byte = stb;
      `CMSR_OFF_RLIM: rd_byte = {4'h0, rlim};
      `CMSR_OFF_RTIM: rd_byte = rtim;
      `CMSR_OFF_OVTIM: rd_byte = ovtim;
      default: ;
    endcase
  end

  // Serial port
  always_comb begin
    rise = scl_in && !scl_q;
    fall = !scl_in && scl_q;
    start_c = scl_in && scl_q && sda_q && !sda_in;
    stop_c = scl_in && scl_q && !sda_q && sda_in;
    next_state = state;
    next_sh = sh;
    next_cnt = cnt;
    next_ptr = ptr;
    next_ptr_phase = ptr_phase;
    next_rw = rw;
    next_oe = sda_oe;
    next_busy = busy;
    wr_en = 1'b0;
    rd_load = 1'b0;
    if (start_c) begin
      next_state = cmsr_addr;
      next_cnt = 4'h0;
      next_busy = 1'b1;
      next_oe = 1'b0;
      next_ptr_phase = 1'b1;
    end else if (stop_c) begin
      next_state = cmsr_idle;
      next_busy = 1'b0;
      next_oe = 1'b0;
    end else begin
      case (state)
        cmsr_addr, cmsr_wr: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_in};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            if (state == cmsr_wr) begin
              next_state = cmsr_wr_ack;
              next_oe = 1'b1;
              wr_en = !ptr_phase;
              next_ptr_phase = 1'b0;
              next_ptr = ptr_phase ? sh : ptr + 8'h01;
            end else if (sh[7:1] == DEV_ADDR) begin
              next_state = cmsr_addr_ack;
              next_oe = 1'b1;
              next_rw = sh[0];
            end else begin
              next_state = cmsr_idle;
            end
          end
        end
        cmsr_addr_ack, cmsr_rd_ack: begin
          if (rise && state == cmsr_rd_ack && sda_in) begin
            // Master refused the byte: release and wait for stop
            next_state = cmsr_idle;
          end else if (fall && (rw || state == cmsr_rd_ack)) begin
            rd_load = 1'b1;
            next_state = cmsr_rd;
            next_sh = rd_byte;
            next_oe = !rd_byte[7];
            next_ptr = ptr + 8'h01;
          end else if (fall) begin
            next_state = cmsr_wr;
            next_oe = 1'b0;
          end
        end
        cmsr_wr_ack: begin
          if (fall) begin
            next_state = cmsr_wr;
            next_oe = 1'b0;
          end
        end
        cmsr_rd: begin
          if (fall && cnt == 4'h7) begin
            next_state = cmsr_rd_ack;
            next_oe = 1'b0;
            next_cnt = 4'h0;
          end else if (fall) begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = !sh[6];
            next_cnt = cnt + 4'h1;
          end
        end
        cmsr_idle: ;
        default: next_state = cmsr_idle;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cmsr_idle;
      sh <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      ptr_phase <= 1'b0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      state <= next_state;
      sh <= next_sh;
      cnt <= next_cnt;
      ptr <= next_ptr;
      ptr_phase <= next_ptr_phase;
      rw <= next_rw;
      sda_oe <= next_oe;
      busy <= next_busy;
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_out = 1'b0;

  // Control registers
  always_comb begin
    next_ctrl = ctrl;
    next_conv = conv;
    next_rlim = rlim;
    next_rtim = rtim;
    next_ovtim = ovtim;
    fault_off = flt_fault[1] || flt_fault[0] || thermal_shutdown_flag ||
                forward_overcurrent_flag || switch_off_event; // R09
    if (wr_en) begin
      case (ptr)
        `CMSR_OFF_CTRL: next_ctrl = sh;
        `CMSR_OFF_CONV: next_conv = sh; // R21
        `CMSR_OFF_RLIM: next_rlim = (sh[3:0] > `CMSR_RLIM_MAX) ?
                                    `CMSR_RLIM_MAX : sh[3:0]; // R16
        `CMSR_OFF_RTIM: next_rtim = sh;
        `CMSR_OFF_OVTIM: next_ovtim = sh;
        default: ;
      endcase
    end
    // Safety first: a fault beats a host write of the enable
    if (fault_off) begin
      next_ctrl[`CMSR_CHG_BIT] = 1'b0; // R22
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CMSR_RST_CTRL; // R22
      conv <= `CMSR_RST_CONV; // R21
      rlim <= 4'(`CMSR_RST_RLIM); // R16
      rtim <= `CMSR_RST_RTIM; // R17 R18
      ovtim <= `CMSR_RST_OVTIM; // R19 R20
    end else begin
      ctrl <= next_ctrl;
      conv <= next_conv;
      rlim <= next_rlim;
      rtim <= next_rtim;
      ovtim <= next_ovtim;
    end
  end

  assign charge_switch_enable = ctrl[`CMSR_CHG_BIT];
  assign convert_continuous = conv[`CMSR_MODE_BIT];
  assign reverse_overcurrent_threshold = rlim;

  // Results and status
  always_comb begin
    // Hold results while a transfer is open so pairs never tear
    update = (meas_valid || pending) && !busy; // R24
    next_pending = (meas_valid || pending) && busy; // R24
    next_res_hi = res_hi;
    next_res_lo = res_lo;
    next_tdie = tdie;
    if (update) begin
      next_res_hi = cap_hi; // R24
      next_res_lo = cap_lo;
      next_tdie = die_temp; // R05
    end
    next_adc_done = adc_done;
    if (rd_load && ptr == `CMSR_OFF_STB) begin
      next_adc_done = 1'b0;
    end
    if (update && !convert_continuous) begin
      next_adc_done = 1'b1; // R11
    end
    next_sta = {flt_fault[0], input_current_regulating_flag, // R06 R07
                battery_voltage_regulating_flag, 1'b0,
                output_voltage_regulating_flag, // R07
                input_side_overtemp_flag, battery_side_overtemp_flag, // R08
                flt_fault[1]}; // R09
    next_stb = {charge_switch_enable && low_current_raw, // R10
                next_adc_done, dropout_alarm_flag, // R11 R12
                dropout_overvoltage_flag, input_present_flag, // R12 R13
                battery_present_flag, thermal_shutdown_flag, // R13 R14
                forward_overcurrent_flag}; // R15
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_hi <= HI_RST; // R04
      res_lo <= LO_RST;
      tdie <= 8'h00; // R05
      pending <= 1'b0;
      adc_done <= 1'b0;
      sta <= 8'h00;
      stb <= 8'h00;
    end else begin
      res_hi <= next_res_hi;
      res_lo <= next_res_lo;
      tdie <= next_tdie;
      pending <= next_pending;
      adc_done <= next_adc_done;
      sta <= next_sta;
      stb <= next_stb;
    end
  end

  // 111 ns tick, rounded up so no deglitch ends early
  always_comb begin
    tick = div == TICK_LAST; // R23
    next_div = tick ? 3'h0 : div + 3'h1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 3'h0;
    end else begin
      div <= next_div;
    end
  end
endmodule
`default_nettype wire

// [testbench/cmsr_host_model.sv]
/*
  Two-wire host model for the register bank: start, stop, 9-bit slots.
  Assumes the bench resolves SDA with a pull-up.
*/
`default_nettype none
module cmsr_host_model (
  // Clock
  input wire logic mclk,
  // Bus
  input wire logic sda_line,
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Data bits move SDA while SCL is low; start and stop move it while SCL is high
  task automatic start();
    sda_drv <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(1);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b1;
    hold(4);
  endtask
  // Byte plus acknowledge slot; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= tx[i];
      hold(4);
      scl <= 1'b1;
      hold(4);
      rx[i] = sda_line;
      scl <= 1'b0;
      hold(1);
    end
  endtask
endmodule
`default_nettype wire

// [testbench/cmsr_regs_assertions.sv]
/*
  Checker on the switch and discharge outputs of the register bank.
  Assumes it is bound into cmsr_regs and sees its ports only.
*/
`default_nettype none
module cmsr_regs_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fault causes
  input wire logic input_overvoltage_raw,
  input wire logic reverse_current_raw,
  input wire logic thermal_shutdown_flag,
  input wire logic forward_overcurrent_flag,
  input wire logic switch_off_event,
  // Outputs
  input wire logic charge_switch_enable,
  input wire logic convert_continuous,
  input wire logic [3:0] reverse_overcurrent_threshold,
  input wire logic [1:0] fast_discharge_output
);
  logic [9:0] rev_len, ov_len, next_rev_len, next_ov_len;
  // Pulses run hundreds of cycles, too long for a repetition
  always_comb begin
    next_rev_len = fast_discharge_output[1] ? rev_len + 10'h001 : 10'h000;
    next_ov_len = fast_discharge_output[0] ? ov_len + 10'h001 : 10'h000;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rev_len <= 10'h000;
      ov_len <= 10'h000;
    end else begin
      rev_len <= next_rev_len;
      ov_len <= next_ov_len;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  fault_clear_a: assert property (
    (thermal_shutdown_flag || forward_overcurrent_flag || switch_off_event)
    |=> !charge_switch_enable) else $error("charge enable kept on fault");
  limit_cap_a: assert property (
    reverse_overcurrent_threshold <= 4'h8) else $error("limit above max");
  reset_state_a: assert property (
    $rose(rst_n) |-> convert_continuous && !charge_switch_enable &&
    reverse_overcurrent_threshold == 4'h1 && fast_discharge_output == 2'h0)
    else $error("bad state after reset");
  rev_width_a: assert property (
    $fell(fast_discharge_output[1]) |-> rev_len == 10'h190 ||
    rev_len == 10'h320) else $error("reverse pulse width wrong");
  ov_width_a: assert property (
    $fell(fast_discharge_output[0]) |-> ov_len == 10'h0c8 ||
    ov_len == 10'h190) else $error("over-voltage pulse width wrong");
  rev_filter_a: assert property (
    $rose(fast_discharge_output[1]) |-> $past(reverse_current_raw, 2) &&
    $past(reverse_current_raw, 12)) else $error("reverse glitch passed");
  ov_filter_a: assert property (
    $rose(fast_discharge_output[0]) |-> $past(input_overvoltage_raw, 2) &&
    $past(input_overvoltage_raw, 12)) else $error("ov glitch passed");
  rev_switch_off_a: assert property (
    $rose(fast_discharge_output[1]) |=> !charge_switch_enable)
    else $error("switch on during reverse fault");
endmodule
bind cmsr_regs cmsr_regs_checker checker_u (
  .mclk, .rst_n, .input_overvoltage_raw, .reverse_current_raw,
  .thermal_shutdown_flag, .forward_overcurrent_flag, .switch_off_event,
  .charge_switch_enable, .convert_continuous,
  .reverse_overcurrent_threshold, .fast_discharge_output
);
`default_nettype wire

// [testbench/test_cmsr_regs.sv]
/*
  Bench for the register bank: reads and writes over the two-wire port.
  Assumes the host model and the bound checker.
*/
`include "cmsr_defines.svh"
`default_nettype none
module test_cmsr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = `CMSR_DEV_ADDR;
  logic mclk = 1'b0, rst_n = 1'b0, mv = 1'b0;
  logic scl, drv, sda, sda_oe, so, cc, cse;
  logic [6:0] sg = 7'h00;
  logic [6:0][12:0] mg = '0;
  logic [7:0] dt = 8'h00;
  logic [1:0] raw = 2'h0, fdo;
  logic [12:0] fl = 13'h0000;
  logic [3:0] thr;
  logic [2:0] ack;
  logic [15:0] d;
  int errors = 0, total_checks = 0, cyc = 0;
  logic [15:0] rtab [23] = '{16'h062a, 16'h078f, 16'h1300, 16'h1400,
    16'h1500, 16'h1600, 16'h1700, 16'h1800, 16'h1900, 16'h1a00, 16'h1b00,
    16'h1c00, 16'h1d00, 16'h1f03, 16'h2084, 16'h2103, 16'h2284, 16'h2300,
    16'h2400, 16'h2500, 16'h2601, 16'h2703, 16'h280c};
  logic [7:0] hi [7] = '{8'h13, 8'h15, 8'h17, 8'h19, 8'h1b, 8'h1f, 8'h21};
  logic [4:0] hm [7] = '{5'h1f, 5'h1f, 5'h1f, 5'h03, 5'h1f, 5'h0f, 5'h0f};
  logic [12:0] pat [2] = '{13'h0555, 13'h0aaa};
  logic [15:0] spat [2] = '{16'h4a2a, 16'h2415};
  logic [7:0] lim [4] = '{8'h00, 8'h08, 8'h09, 8'h0f};
`define CHK(nm, got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected %s: expected %h seen %h", nm, (exp), (got)); \
  end \
end
  // Open drain with pull-up
  assign sda = drv & ~(sda_oe & ~so);
  always #10 mclk = ~mclk;
  cmsr_host_model host_u (.mclk(mclk), .sda_line(sda), .scl(scl),
    .sda_drv(drv));
  cmsr_regs dut_u (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(so), .sda_oe(sda_oe), .meas_valid(mv), .meas_sign(sg),
    .meas_mag(mg), .die_temp(dt), .convert_continuous(cc),
    .input_overvoltage_raw(raw[0]), .reverse_current_raw(raw[1]),
    .input_current_regulating_flag(fl[0]),
    .battery_voltage_regulating_flag(fl[1]),
    .output_voltage_regulating_flag(fl[2]),
    .input_side_overtemp_flag(fl[3]), .battery_side_overtemp_flag(fl[4]),
    .low_current_raw(fl[5]), .dropout_alarm_flag(fl[6]),
    .dropout_overvoltage_flag(fl[7]), .input_present_flag(fl[8]),
    .battery_present_flag(fl[9]), .thermal_shutdown_flag(fl[10]),
    .forward_overcurrent_flag(fl[11]), .switch_off_event(fl[12]),
    .charge_switch_enable(cse), .reverse_overcurrent_threshold(thr),
    .fast_discharge_output(fdo));
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, v);
    logic [8:0] r0, r1, r2;
    host_u.start();
    host_u.xfer({dv, 2'b01}, r0);
    host_u.xfer({a, 1'b1}, r1);
    host_u.xfer({v, 1'b1}, r2);
    host_u.stop();
    ack = {r0[0], r1[0], r2[0]};
  endtask
  task automatic rd(input logic [7:0] a, input bit two,
                    output logic [15:0] q);
    logic [8:0] r;
    q = 16'h0000;
    host_u.start();
    host_u.xfer({DEV, 2'b01}, r);
    host_u.xfer({a, 1'b1}, r);
    host_u.start();
    host_u.xfer({DEV, 2'b11}, r);
    host_u.xfer({8'hff, !two}, r);
    q[15:8] = r[8:1];
    if (two) begin
      host_u.xfer(9'h1ff, r);
      q[7:0] = r[8:1];
    end
    host_u.stop();
  endtask
  function automatic logic [15:0] pair(input logic [12:0] b, input int i);
    logic [12:0] m;
    m = 13'(b + 13'(i) * 13'h0235);
    return {b[i], 2'b00, m[12:8] & hm[i], m[7:0]};
  endfunction
  task automatic meas(input logic [12:0] b);
    for (int i = 0; i < 7; i++) mg[i] <= 13'(b + 13'(i) * 13'h0235);
    sg <= b[6:0];
    dt <= b[7:0] ^ 8'h5a;
    mv <= 1'b1;
    hold(1);
    mv <= 1'b0;
    hold(2);
  endtask
  task automatic chk_meas(input logic [12:0] b);
    logic [15:0] q;
    for (int i = 0; i < 7; i++) begin
      rd(hi[i], 1, q);
      `CHK("result pair", q, pair(b, i))
    end
    rd(8'h23, 0, q);
    `CHK("die temperature", q[15:8], b[7:0] ^ 8'h5a)
  endtask
  task automatic fault(input int ch, input logic [7:0] v, input int t, w);
    int n;
    int first;
    logic [15:0] q;
    n = 0;
    first = 0;
    wr(DEV, 8'h28 - 8'(ch), v);
    wr(DEV, 8'h06, 8'h3a);
    raw[ch] <= 1'b1;
    hold(6 * t - 8);
    raw[ch] <= 1'b0;
    hold(3);
    raw[ch] <= 1'b1;
    for (int i = 1; i < 6 * t + 900; i++) begin
      @(negedge mclk);
      if (fdo[ch] === 1'b1) begin
        n++;
        if (first == 0) first = i;
      end
    end
    `CHK("discharge width", n, w)
    if (w > 0) `CHK("filter delay", first > 6 * t - 9, 1'b1)
    rd(8'h24, 0, q);
    `CHK("fault status", q[15:8], ch ? 8'h01 : 8'h80)
    `CHK("switch off", cse, 1'b0)
    raw[ch] <= 1'b0;
    hold(3);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Ceiling well above the roughly 42000 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    hold(2);
    rst_n <= 1'b1;
    hold(3);
    foreach (rtab[k]) begin
      rd(rtab[k][15:8], 0, d);
      `CHK("reset value", d[15:8], rtab[k][7:0])
    end
    wr(DEV, 8'h07, 8'h8b);
    `CHK("mode", cc, 1'b0)
    meas(13'h1abc);
    rd(8'h25, 0, d);
    `CHK("done flag", d[15:8], 8'h40)
    rd(8'h25, 0, d);
    `CHK("done cleared", d[15:8], 8'h00)
    chk_meas(13'h1abc);
    wr(DEV, 8'h07, 8'h8f);
    `CHK("mode", cc, 1'b1)
    fork
      rd(8'h13, 1, d);
      begin
        hold(250);
        meas(13'h0c3d);
      end
    join
    `CHK("frozen pair", d, pair(13'h1abc, 0))
    chk_meas(13'h0c3d);
    foreach (pat[k]) begin
      fl <= pat[k];
      hold(3);
      rd(8'h24, 1, d);
      `CHK("status", d, spat[k])
    end
    fl <= 13'h0020;
    for (int k = 10; k < 13; k++) begin
      wr(DEV, 8'h06, 8'h3a);
      `CHK("charge enable", cse, 1'b1)
      rd(8'h25, 0, d);
      `CHK("low charge alarm", d[15:8], 8'h80)
      fl[k] <= 1'b1;
      hold(1);
      fl[k] <= 1'b0;
      hold(3);
      `CHK("charge cleared", cse, 1'b0)
      rd(8'h06, 0, d);
      `CHK("control", d[15:8], 8'h2a)
    end
    fl <= 13'h0000;
    foreach (lim[k]) begin
      wr(DEV, 8'h26, lim[k]);
      `CHK("limit", thr, lim[k] > 8'h08 ? 4'h8 : lim[k][3:0])
      rd(8'h26, 0, d);
      `CHK("limit read", d[15:8], lim[k] > 8'h08 ? 8'h08 : lim[k])
    end
    wr(DEV ^ 7'h01, 8'h26, 8'h03);
    `CHK("foreign address", ack, 3'b111)
    `CHK("limit kept", thr, 4'h8)
    wr(DEV, 8'h23, 8'h55);
    rd(8'h23, 0, d);
    `CHK("read-only", d[15:8], 8'h3d ^ 8'h5a)
    fault(0, 8'h0c, 4, 0);
    for (int c = 0; c < 4; c++) begin
      fault(1, {4'h0, 2'(c), 1'b1, c[0]}, 32 >> c, c[0] ? 400 : 800);
      fault(0, {4'h0, 2'(c), 1'b1, c[0]}, 32 >> c, c[0] ? 200 : 400);
    end
    stop_test();
  end
endmodule
`default_nettype wire
